// [pkg/dskm_pkg.sv]
// shared constants and types for the double slot key stream masking block
package dskm_pkg;

  // field geometry, in bits
  localparam logic [9:0] SEG_LEN    = 10'h348; // 840 bits per segment
  localparam logic [9:0] SEG_LAST   = 10'h347; // index 839
  localparam logic [9:0] TAIL_LEN   = 10'h028; // 40 tail bits
  localparam logic [9:0] SINGLE_LEN = 10'h300; // 768 data bits
  localparam logic [9:0] SUB_PITCH  = 10'h050; // 80 bit subfield
  localparam logic [9:0] SUB_DATA   = 10'h040; // 64 data bits
  localparam logic [9:0] B_LEN      = 10'h320; // 800 B-field bits
  localparam logic [10:0] FRAME_BITS = 11'h690; // 1680 bits per frame

  // connections and bearers
  localparam int CONN_W = 3;
  localparam int NUM_CONN = 8;
  localparam int BEAR_W = 3;
  localparam int NUM_BEAR = 8;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CONN   = 8'h04;
  localparam logic [7:0] OFS_GROUP  = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_COUNT  = 8'h10;

  // register fields and reset values
  localparam int CTRL_EN_BIT    = 0;
  localparam int GROUP_MODE_BIT = 8;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_SEG_BIT   = 1;
  localparam int STAT_IDX_LSB   = 4;
  localparam int STAT_BUF_LSB   = 16;
  localparam logic        CTRL_RST = 1'b0;
  localparam logic [7:0]  CONN_RST = 8'h00;

  // ahb transfer type bit that marks an active transfer
  localparam int HTRANS_ACT_BIT = 1;
  localparam logic [1:0] BUF_DEPTH = 2'h2;

  // B-field format carried with each D-field
  typedef enum logic [2:0] {
    FMT_UNPROT = 3'h0,
    FMT_SINGLE = 3'h1,
    FMT_MULTI  = 3'h2,
    FMT_ETYPE  = 3'h3,
    FMT_ENCODED = 3'h4
  } dskm_fmt_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } dskm_state_e;

  // one field bit from the assembly path, descriptor valid on first
  typedef struct packed {
    logic              data;
    logic              first;
    dskm_fmt_e         fmt;
    logic              tail_ct;
    logic              cplane;
    logic              lc_ciph;
    logic [9:0]        enc_len;
    logic [CONN_W-1:0] conn;
    logic [BEAR_W-1:0] bearer;
    logic [3:0]        frame;
    logic [23:0]       mframe;
  } dskm_field_s;

  // one masked bit toward the assembly path
  typedef struct packed {
    logic data;
    logic first;
    logic last;
    logic seg;
    logic masked;
  } dskm_out_s;

  // start request toward the key stream generator
  typedef struct packed {
    logic [BEAR_W-1:0] bearer;
    logic [3:0]        frame;
    logic [23:0]       mframe;
  } dskm_iv_s;

endpackage

// [rtl/dskm_masker.sv]
// double slot key stream masking unit with ahb-lite registers
// Overview of operation
// - each D-field pair gets two key segments of 840 bits, indices 0..839.
// - control-tail type: segment bits 0..39 mask A-field bits 8..47.
// - other tail types: segment bits 0..39 consumed, tail passes unchanged.
// - unprotected B-field: segment bits 40..839 mask B bits 0..799.
// - single subfield: bits 40..807 mask B 0..767; 808..839 unused.
// - multi subfield: bits 40..103 mask B0 data; 104..119 unused.
// - subfield k data at B 80k masked from segment bit 40+80k, 16 unused.
// - multi subfield: segment bits 824..839 generated but never applied.
// - E-type and E+U multiplexer use the multi subfield mapping.
// - encoded format: first 800*r payload bits masked before coding.
// - encoded format: segment bits past the payload up to 839 dropped.
// - one frame consumes two segments, 1680 concatenated key bits.
// - each bearer enciphered alone; start value from frame and multiframe.
// - double simplex: first D-field uses segment one, second segment two.
// - per-connection enable; one setting applies to all its bearers.
// - connections of one call or data link set to one mode together.
// - control data in clear unless its link control is enciphered.
// - no key bits for header, check bits or X; check positions unused.
`timescale 1ns/1ns
module dskm_masker (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset,
  // ahb-lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  // field bits from the assembly path
  input  wire logic                 in_valid,
  input  wire dskm_pkg::dskm_field_s in_bit,
  output logic                      in_ready,
  // key stream from the generator
  input  wire logic                 ks_valid,
  input  wire logic                 ks_bit,
  output logic                      ks_ready,
  output logic                      kg_req,
  output dskm_pkg::dskm_iv_s        kg_iv,
  // masked bits toward the assembly path
  output logic                      out_valid,
  output dskm_pkg::dskm_out_s       out_bit,
  input  wire logic                 out_ready
);

  // decides whether key bit idx is applied to the field bit
  function automatic logic key_used(input logic [9:0] idx,
                                    input dskm_pkg::dskm_fmt_e fmt,
                                    input logic tail_ct,
                                    input logic [9:0] enc_len);
    logic [9:0] b;
    logic [9:0] sub;
    b = idx - dskm_pkg::TAIL_LEN;
    sub = b % dskm_pkg::SUB_PITCH;
    key_used = 1'b0;
    if (idx < dskm_pkg::TAIL_LEN) begin
      key_used = tail_ct;
    end else begin
      unique case (fmt)
        dskm_pkg::FMT_UNPROT: key_used = 1'b1;
        dskm_pkg::FMT_SINGLE: key_used = b < dskm_pkg::SINGLE_LEN;
        dskm_pkg::FMT_MULTI,
        dskm_pkg::FMT_ETYPE: key_used = sub < dskm_pkg::SUB_DATA;
        dskm_pkg::FMT_ENCODED: key_used = b < enc_len;
        default: key_used = 1'b0;
      endcase
    end
  endfunction

  // true when the data phase now ending writes the register at ofs
  function automatic logic wr_hit(input logic       wr,
                                  input logic [7:0] addr,
                                  input logic [7:0] ofs);
    wr_hit = wr && addr == ofs;
  endfunction

  // group write: mode bit set turns masked connections on, else off
  function automatic logic [7:0] group_apply(input logic [7:0]  cur_en,
                                             input logic [31:0] wdata);
    if (wdata[dskm_pkg::GROUP_MODE_BIT]) begin
      group_apply = cur_en | wdata[7:0];
    end else begin
      group_apply = cur_en & ~wdata[7:0];
    end
  endfunction

  // register file state
  logic        ctrl_en;
  logic [7:0]  conn_en;
  logic [31:0] field_count;

  // register values as a read in this address phase must see them
  logic        rd_ctrl;
  logic [7:0]  rd_conn;
  logic [31:0] status_word;

  // bus data phase state
  logic        dp_write;
  logic [7:0]  dp_addr;

  // masking state
  dskm_pkg::dskm_state_e state;
  dskm_pkg::dskm_state_e next_state;
  logic [9:0]             idx_q;
  dskm_pkg::dskm_field_s  desc_q;
  logic [dskm_pkg::NUM_BEAR-1:0] seg_of;
  logic                   kg_sent;
  logic [10:0]            frame_bits;

  // two-entry output buffer
  dskm_pkg::dskm_out_s buf_mem [2];
  logic                buf_wp;
  logic                buf_rp;
  logic [1:0]          buf_cnt;

  // combinational terms
  logic                  room;
  logic                  xfer;
  logic [9:0]            cur_idx;
  dskm_pkg::dskm_field_s cur;
  logic                  conn_on;
  logic                  apply;
  logic                  last_bit;
  logic                  cur_seg;
  logic                  pop;
  logic                  addr_ok;

  // bus answers at once, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_ok   = hsel & htrans[dskm_pkg::HTRANS_ACT_BIT] & hready;

  // handshakes: a bit moves only with a key bit and buffer room
  assign room     = buf_cnt < dskm_pkg::BUF_DEPTH;
  assign in_ready = ks_valid & room;
  assign ks_ready = in_valid & room;
  assign xfer     = in_valid & ks_valid & room;

  // descriptor and index of the bit now offered
  always_comb begin
    cur     = in_bit.first ? in_bit : desc_q;
    cur.data = in_bit.data;
    cur_idx = in_bit.first ? 10'h000 : idx_q;
  end

  // enable check: global, per connection, and control plane routing
  assign conn_on = ctrl_en & conn_en[cur.conn];
  assign apply   = conn_on & ~(cur.cplane & ~cur.lc_ciph)
                 & key_used(cur_idx, cur.fmt, cur.tail_ct, cur.enc_len);
  assign last_bit = cur_idx == dskm_pkg::SEG_LAST;
  assign cur_seg  = seg_of[cur.bearer];
  assign pop      = out_valid & out_ready;

  // address phase capture
  always_ff @(posedge clk) begin
    if (reset) begin
      dp_write <= 1'b0;
      dp_addr  <= 8'h00;
    end else begin
      dp_write <= addr_ok & hwrite;
      dp_addr  <= addr_ok ? haddr[7:0] : dp_addr;
    end
  end

  // a read right behind a write sees the value being written, since
  // the write lands on the same edge that captures the read data
  always_comb begin
    rd_ctrl = ctrl_en;
    rd_conn = conn_en;
    if (wr_hit(dp_write, dp_addr, dskm_pkg::OFS_CTRL)) begin
      rd_ctrl = hwdata[dskm_pkg::CTRL_EN_BIT];
    end
    if (wr_hit(dp_write, dp_addr, dskm_pkg::OFS_CONN)) begin
      rd_conn = hwdata[7:0];
    end else if (wr_hit(dp_write, dp_addr, dskm_pkg::OFS_GROUP)) begin
      rd_conn = group_apply(conn_en, hwdata);
    end
  end

  // status word assembled from its field positions
  always_comb begin
    status_word = 32'h00000000;
    status_word[dskm_pkg::STAT_BUSY_BIT] = state == dskm_pkg::ST_RUN;
    status_word[dskm_pkg::STAT_SEG_BIT] = cur_seg;
    status_word[dskm_pkg::STAT_IDX_LSB +: 10] = idx_q;
    status_word[dskm_pkg::STAT_BUF_LSB +: 2] = buf_cnt;
  end

  // read data registered from the address phase
  always_ff @(posedge clk) begin
    if (reset) begin
      hrdata <= 32'h00000000;
    end else if (addr_ok & ~hwrite) begin
      unique case (haddr[7:0])
        dskm_pkg::OFS_CTRL:   hrdata <= {31'h00000000, rd_ctrl};
        dskm_pkg::OFS_CONN:   hrdata <= {24'h000000, rd_conn};
        dskm_pkg::OFS_STATUS: hrdata <= status_word;
        dskm_pkg::OFS_COUNT:  hrdata <= field_count;
        default:              hrdata <= 32'h00000000;
      endcase
    end
  end

  // global enable register
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_en <= dskm_pkg::CTRL_RST;
    end else if (wr_hit(dp_write, dp_addr, dskm_pkg::OFS_CTRL)) begin
      ctrl_en <= hwdata[dskm_pkg::CTRL_EN_BIT];
    end
  end

  // connection enables; group write sets a call's connections together
  always_ff @(posedge clk) begin
    if (reset) begin
      conn_en <= dskm_pkg::CONN_RST;
    end else if (wr_hit(dp_write, dp_addr, dskm_pkg::OFS_CONN)) begin
      conn_en <= hwdata[7:0];
    end else if (wr_hit(dp_write, dp_addr, dskm_pkg::OFS_GROUP)) begin
      conn_en <= group_apply(conn_en, hwdata);
    end
  end

  // field state machine
  always_comb begin
    next_state = state;
    unique case (state)
      dskm_pkg::ST_IDLE: if (xfer && in_bit.first) next_state = dskm_pkg::ST_RUN;
      dskm_pkg::ST_RUN:  if (xfer && last_bit) next_state = dskm_pkg::ST_IDLE;
      default:           next_state = dskm_pkg::ST_IDLE;
    endcase
    if (xfer && in_bit.first && last_bit) begin
      next_state = dskm_pkg::ST_IDLE;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= dskm_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // segment index and descriptor, one step per field bit
  always_ff @(posedge clk) begin
    if (reset) begin
      idx_q  <= 10'h000;
      desc_q <= '0;
    end else if (xfer) begin
      idx_q  <= last_bit ? 10'h000 : cur_idx + 10'h001;
      desc_q <= cur;
    end
  end

  // per-bearer segment select, flips after each D-field
  always_ff @(posedge clk) begin
    if (reset) begin
      seg_of <= '0;
    end else if (xfer && last_bit) begin
      seg_of[cur.bearer] <= ~cur_seg;
    end
  end

  // key bits used this frame, header and X never counted
  always_ff @(posedge clk) begin
    if (reset) begin
      frame_bits <= 11'h000;
    end else if (xfer) begin
      frame_bits <= (frame_bits == dskm_pkg::FRAME_BITS - 11'h001) ?
                    11'h000 : frame_bits + 11'h001;
    end
  end

  // field counter for software
  always_ff @(posedge clk) begin
    if (reset) begin
      field_count <= 32'h00000000;
    end else if (xfer && last_bit) begin
      field_count <= field_count + 32'h00000001;
    end
  end

  // generator start request before the first D-field of a bearer's pair
  always_ff @(posedge clk) begin
    if (reset) begin
      kg_req  <= 1'b0;
      kg_sent <= 1'b0;
      kg_iv   <= '0;
    end else begin
      kg_req <= 1'b0;
      if (in_valid && in_bit.first && !seg_of[in_bit.bearer] && !kg_sent) begin
        kg_req  <= 1'b1;
        kg_sent <= 1'b1;
        kg_iv   <= '{bearer: in_bit.bearer, frame: in_bit.frame,
                     mframe: in_bit.mframe};
      end
      if (xfer && in_bit.first) begin
        kg_sent <= 1'b0;
      end
    end
  end

  // buffer write: masked bit, or plain bit when the key is not applied
  always_ff @(posedge clk) begin
    if (reset) begin
      buf_mem[0] <= '0;
      buf_mem[1] <= '0;
      buf_wp     <= 1'b0;
    end else if (xfer) begin
      buf_mem[buf_wp] <= '{data: in_bit.data ^ (ks_bit & apply),
                           first: in_bit.first, last: last_bit,
                           seg: cur_seg, masked: apply};
      buf_wp <= ~buf_wp;
    end
  end

  // buffer read pointer and fill level
  always_ff @(posedge clk) begin
    if (reset) begin
      buf_rp  <= 1'b0;
      buf_cnt <= 2'h0;
    end else begin
      if (pop) begin
        buf_rp <= ~buf_rp;
      end
      buf_cnt <= buf_cnt + {1'b0, xfer} - {1'b0, pop};
    end
  end

  // buffer outputs
  assign out_valid = buf_cnt != 2'h0;
  assign out_bit   = buf_mem[buf_rp];

endmodule

// [test/dskm_keygen_model.sv]
// key stream generator model answering start requests with key bits
`timescale 1ns/1ns
module dskm_keygen_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // generator handshake
  input  wire logic kg_req,
  input  wire logic slow,
  input  wire logic ks_ready,
  output logic      ks_valid,
  output logic      ks_bit
);
  int budget;

  // two segments per start, no bits for header or x, held until taken
  always_ff @(posedge clk) begin
    if (reset) begin
      budget   <= 0;
      ks_valid <= 1'b0;
      ks_bit   <= 1'b0;
    end else begin
      budget <= budget + (kg_req ? 1680 : 0)
                - int'(ks_valid && ks_ready);
      if (!ks_valid || ks_ready) begin
        ks_valid <= budget > int'(ks_valid && ks_ready)
                    && (!slow || $urandom % 3 == 0);
        ks_bit   <= 1'($urandom); // idle bit keeps changing
      end
    end
  end
endmodule

// [test/dskm_props.sv]
// port assertions for the masking block
`timescale 1ns/1ns
module dskm_props (
  // clock and reset
  input wire logic                   clk,
  input wire logic                   reset,
  // register bus
  input wire logic                   hsel,
  input wire logic                   hwrite,
  input wire logic                   hready,
  input wire logic                   hreadyout,
  input wire logic                   hresp,
  input wire logic [31:0]            haddr,
  input wire logic [31:0]            hrdata,
  input wire logic [1:0]             htrans,
  // streams
  input wire logic                   in_valid,
  input wire logic                   in_ready,
  input wire logic                   ks_valid,
  input wire logic                   ks_ready,
  input wire logic                   kg_req,
  input wire logic                   out_valid,
  input wire logic                   out_ready,
  input wire dskm_pkg::dskm_field_s  in_bit,
  input wire dskm_pkg::dskm_out_s    out_bit,
  input wire dskm_pkg::dskm_iv_s     kg_iv
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // field and key bits consumed together, results follow and hold
  property p_pair;
    (in_valid && in_ready) == (ks_valid && ks_ready);
  endproperty
  a_pair: assert property (p_pair) else $error("field key take split");
  property p_out;
    in_valid && in_ready |=> out_valid;
  endproperty
  a_out: assert property (p_out) else $error("taken bit not offered");
  property p_hold;
    out_valid && !out_ready |=> out_valid && $stable(out_bit);
  endproperty
  a_hold: assert property (p_hold) else $error("output bit dropped");
  // start request is one pulse caused by a first bit, carrying its ids
  property p_pulse;
    kg_req |=> !kg_req;
  endproperty
  a_pulse: assert property (p_pulse) else $error("start pulse too long");
  property p_cause;
    kg_req |-> $past(in_valid) && $past(in_bit.first);
  endproperty
  a_cause: assert property (p_cause) else $error("start without field");
  property p_iv;
    kg_req |-> kg_iv.bearer == $past(in_bit.bearer)
      && kg_iv.frame == $past(in_bit.frame)
      && kg_iv.mframe == $past(in_bit.mframe);
  endproperty
  a_iv: assert property (p_iv) else $error("start value mismatch");
  property p_rst;
    $fell(reset) |-> !out_valid && !kg_req;
  endproperty
  a_rst: assert property (p_rst) else $error("output active after reset");
  // bus answers at once, unmapped reads give zero
  property p_bus;
    hreadyout && !hresp;
  endproperty
  a_bus: assert property (p_bus) else $error("bus wait or error");
  property p_unmapped;
    hsel && htrans[1] && hready && !hwrite && haddr[7:0] > 8'h10
      |=> hrdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  // main scenarios
  c_full: cover property (in_valid && ks_valid && !in_ready);
  c_req: cover property (kg_req);
  c_stall: cover property (out_valid && !out_ready);
endmodule

bind dskm_masker dskm_props dskm_props_inst (.*);

// [test/tb.sv]
// self-checking testbench for the masking block
`timescale 1ns/1ns
module tb;
  logic clk, reset, hsel, hwrite, hready, hreadyout, hresp, slow;
  logic in_valid, in_ready, ks_valid, ks_bit, ks_ready, kg_req;
  logic out_valid, out_ready, ctrl_en, m;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  conn_en, seg;
  dskm_pkg::dskm_field_s in_bit;
  dskm_pkg::dskm_out_s   out_bit, e, q[$];
  dskm_pkg::dskm_iv_s    kg_iv;
  int mismatches, n_checks, idx;

  assign hready = hreadyout;
  dskm_masker dskm_masker_inst (.*);
  dskm_keygen_model dskm_keygen_model_inst (.*);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, s, x);
    end
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // bounded wait step
  task automatic bump(inout int n);
    n++;
    if (n > 4000) begin
      mismatches++;
      final_report();
    end
  endtask

  // one single word transfer, read data left in rd
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do begin @(posedge clk); bump(n); end while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge clk); bump(n); end while (hready !== 1'b1);
    rd = hrdata; // hsel stays up with htrans idle between transfers
  endtask

  // one double slot field of 840 bits, descriptor fixed except frame and mframe, which change every bit
  task automatic field(input dskm_pkg::dskm_fmt_e f, input logic t, cp, lc,
                       input logic [2:0] b);
    int n;
    for (int i = 0; i < 840; i++) begin
      in_valid <= 1'b1;
      in_bit <= '{data: 1'($urandom), first: i == 0, fmt: f, tail_ct: t,
        cplane: cp, lc_ciph: lc, enc_len: 10'h190, conn: 3'(b[0] + b[1]),
        bearer: b, frame: 4'($urandom), mframe: 24'($urandom)};
      n = 0;
      do begin @(posedge clk); bump(n); end while (in_ready !== 1'b1);
    end
    in_valid <= 1'b0;
    @(posedge clk); // let the drop be seen before a new field
  endtask

  // key bit use for field bit i
  function automatic logic apply(int i, dskm_pkg::dskm_field_s d);
    if (!ctrl_en || !conn_en[d.conn] || (d.cplane && !d.lc_ciph)) return 0;
    if (i < 40) return d.tail_ct;
    case (d.fmt)
      dskm_pkg::FMT_UNPROT: return 1'b1;
      dskm_pkg::FMT_SINGLE: return i - 40 < 768;
      dskm_pkg::FMT_ENCODED: return i - 40 < d.enc_len;
      default: return (i - 40) % 80 < 64;
    endcase
  endfunction

  // note expected bits on take, compare on delivery
  always @(posedge clk) begin
    if (!reset && in_valid && in_ready) begin
      idx = in_bit.first ? 0 : idx + 1;
      m = apply(idx, in_bit);
      q.push_back('{data: in_bit.data ^ (ks_bit & m), first: in_bit.first,
        last: idx == 839, seg: seg[in_bit.bearer], masked: m});
      if (idx == 839) seg[in_bit.bearer] = ~seg[in_bit.bearer];
    end
    if (!reset && out_valid && out_ready) begin
      if (q.size() == 0) chk(32'h1, 32'h0);
      else begin
        e = q.pop_front();
        chk(32'(out_bit), 32'(e));
      end
    end
  end

  // receiver stalls at random
  always @(posedge clk) out_ready <= $urandom % 4 != 0;

  initial begin
    int n;
    {in_valid, hsel, htrans, hwrite, haddr, hwdata, slow} = '0;
    in_bit = '0;
    hsize = 3'h2;
    out_ready = 1'b0;
    reset = 1'b1;
    {mismatches, n_checks, idx, seg, ctrl_en, conn_en} = '0;
    void'($urandom(51));
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    ahb(1'b0, 8'h00, 0);
    chk(rd, 32'h0);
    ahb(1'b0, 8'h04, 0);
    chk(rd, 32'h0);
    ahb(1'b1, 8'h24, 32'hffff_ffff);
    ahb(1'b0, 8'h24, 0);
    chk(rd, 32'h0);
    field(dskm_pkg::FMT_UNPROT, 1'b1, 1'b0, 1'b0, 3'h1);
    ahb(1'b1, 8'h00, 32'h1);
    ctrl_en = 1'b1;
    ahb(1'b1, 8'h08, 32'h106);
    conn_en = 8'h06;
    ahb(1'b0, 8'h04, 0);
    chk(rd, 32'h6);
    for (int f = 0; f < 5; f++)
      field(dskm_pkg::dskm_fmt_e'(f), f[0], 1'b0, 1'b0, 3'h1);
    ahb(1'b1, 8'h08, 32'h004);
    conn_en = 8'h02;
    field(dskm_pkg::FMT_MULTI, 1'b1, 1'b0, 1'b0, 3'h2);
    field(dskm_pkg::FMT_UNPROT, 1'b1, 1'b1, 1'b0, 3'h1);
    slow <= 1'b1;
    field(dskm_pkg::FMT_UNPROT, 1'b1, 1'b1, 1'b1, 3'h1);
    field(dskm_pkg::FMT_ETYPE, 1'b1, 1'b0, 1'b0, 3'h3);
    field(dskm_pkg::FMT_SINGLE, 1'b0, 1'b0, 1'b0, 3'h3);
    n = 0;
    while (q.size() != 0) begin
      @(posedge clk);
      bump(n);
    end
    ahb(1'b0, 8'h0c, 0);
    chk(rd, {30'h0, seg[3], 1'b0});
    ahb(1'b0, 8'h10, 0);
    chk(rd, 32'hb);
    final_report();
  end
endmodule
